// File: design/sfe_pkg.sv
// Purpose: Shared constants for the serial flash erase, power-down and ID command block
// Assumes: System clock pclk at 100 MHz; nanosecond times are converted to cycle counts here
// Notes:   Identification values live as parameters of the top module, not here
package sfe_pkg;

   // Clock
   localparam logic [31:0] CLK_NS     = 32'h0000000A;       // 10 ns period
   localparam logic [31:0] CYC_PER_MS = 32'h000186A0;       // 100000 cycles per ms

   // Self-timed durations, in their own units (plain defaults)
   localparam logic [31:0] BLK_ERASE_MS  = 32'h00000096;    // block_erase_time, 150 ms
   localparam logic [31:0] CHIP_ERASE_MS = 32'h00000BB8;    // chip_erase_time, 3000 ms
   localparam logic [31:0] PD_ENTRY_NS   = 32'h00000BB8;    // power_down_entry_time, 3000 ns
   localparam logic [31:0] REL1_NS       = 32'h00000BB8;    // release_time_1, 3000 ns
   localparam logic [31:0] REL2_NS       = 32'h00000708;    // release_time_2, 1800 ns

   // Nanosecond times round down to whole cycles
   localparam logic [31:0] PD_ENTRY_CYC = PD_ENTRY_NS / CLK_NS;
   localparam logic [31:0] REL1_CYC     = REL1_NS / CLK_NS;
   localparam logic [31:0] REL2_CYC     = REL2_NS / CLK_NS;
   localparam logic [31:0] TMR_ONE      = 32'h00000001;

   // Opcodes
   localparam logic [7:0] OP_WREN     = 8'h06;
   localparam logic [7:0] OP_WRDI     = 8'h04;
   localparam logic [7:0] OP_STATUS   = 8'h05;
   localparam logic [7:0] OP_BLK_ERA  = 8'hD8;
   localparam logic [7:0] OP_CHIP_A   = 8'hC7;
   localparam logic [7:0] OP_CHIP_B   = 8'h60;
   localparam logic [7:0] OP_PDOWN    = 8'hB9;
   localparam logic [7:0] OP_RELEASE  = 8'hAB;
   localparam logic [7:0] OP_MFR_DEV  = 8'h90;
   localparam logic [7:0] OP_MFR_DUAL = 8'h92;
   localparam logic [7:0] OP_UNIQUE   = 8'h4B;
   localparam logic [7:0] OP_JEDEC    = 8'h9F;

   // Frame lengths in clock rising edges
   localparam logic [6:0] EDGE_OP    = 7'h08;               // opcode only
   localparam logic [6:0] EDGE_ADDR  = 7'h20;               // opcode + 24-bit address / 3 dummies
   localparam logic [6:0] EDGE_DUAL  = 7'h18;               // 92h: op + 12 addr + 4 mode edges
   localparam logic [6:0] EDGE_UNIQ  = 7'h28;               // opcode + 4 dummy bytes
   localparam logic [6:0] EDGE_MAX   = 7'h7F;

   // Output word lengths in bits
   localparam logic [6:0] LEN_NONE = 7'h00;
   localparam logic [6:0] LEN_BYTE = 7'h08;
   localparam logic [6:0] LEN_PAIR = 7'h10;
   localparam logic [6:0] LEN_JED  = 7'h18;
   localparam logic [6:0] LEN_UNIQ = 7'h40;

   // Protection map: 8 blocks of 64 KB
   localparam logic [3:0] BLK_COUNT = 4'h8;
   localparam logic [2:0] PL_ALL    = 3'h4;
   localparam logic [2:0] PL_NONE   = 3'h0;

   // APB register map
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int          CTRL_TB     = 0;
   localparam int          CTRL_PL_LO  = 1;
   localparam int          CTRL_PL_HI  = 3;
   localparam logic [3:0]  CTRL_RST    = 4'h0;

   // Pin synchroniser lanes: sck, cs_n, io0, io1
   localparam int         PIN_SCK  = 0;
   localparam int         PIN_CS   = 1;
   localparam int         PIN_IO0  = 2;
   localparam int         PIN_IO1  = 3;
   localparam logic [3:0] PIN_RST  = 4'h2;                  // cs_n idles high

   typedef enum logic [2:0] {
      ST_IDLE, ST_ERASE, ST_PD_ENTRY, ST_PD, ST_RELEASE
   } sfe_state_t;

endpackage

// File: design/sfe_flash_cmd.sv
// Purpose: SPI flash command engine for erase, deep power-down and identification reads
// Assumes: SPI pins are asynchronous and resampled on pclk; pclk far faster than spi_sck
// Notes:   Array erase itself is done by logic behind erase_start / erase_addr / erase_chip
`timescale 1ns/100ps

module sfe_flash_cmd
   import sfe_pkg::*;
#(
   parameter logic [31:0] BLOCK_ERASE_CYC = BLK_ERASE_MS * CYC_PER_MS,  // Block erase cycles
   parameter logic [31:0] CHIP_ERASE_CYC  = CHIP_ERASE_MS * CYC_PER_MS, // Chip erase cycles
   parameter logic [7:0]  MFR_ID    = 8'h5A,              // Arbitrary value
   parameter logic [7:0]  DEV_ID    = 8'h12,              // Arbitrary value
   parameter logic [7:0]  MEM_TYPE  = 8'h30,              // Arbitrary value
   parameter logic [7:0]  CAPACITY  = 8'h13,              // Arbitrary value
   parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // Arbitrary value
) (
   input  wire logic        pclk,        // System clock
   input  wire logic        presetn,     // Async reset, low
   input  wire logic [11:0] paddr,       // APB address
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB access phase
   input  wire logic        pwrite,      // APB direction
   input  wire logic [31:0] pwdata,      // APB write data
   output logic             pready,      // APB ready
   output logic [31:0]      prdata,      // APB read data
   output logic             pslverr,     // APB error on unmapped address
   input  wire logic        spi_sck,     // Serial clock pin
   input  wire logic        spi_cs_n,    // Chip select pin, low
   input  wire logic        io0_in,      // IO0 pin level
   output logic             io0_out,     // IO0 drive value
   output logic             io0_oe,      // IO0 drive enable
   input  wire logic        io1_in,      // IO1 pin level
   output logic             io1_out,     // IO1 drive value
   output logic             io1_oe,      // IO1 drive enable
   output logic             erase_start, // One-cycle erase request to array
   output logic             erase_chip,  // Request covers whole array
   output logic [23:0]      erase_addr,  // Block address of request
   output logic             busy,        // Erase cycle running
   output logic             power_down   // Deep power-down state
);

   // Pin synchronisers, two flops per lane
   logic [3:0] pin_raw;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   assign pin_raw = {io1_in, io0_in, spi_cs_n, spi_sck};

   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_q[i] <= PIN_RST[i];
            s2_q[i] <= PIN_RST[i];
         end else begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
         end
      end
   end

   // Edge detection on the second stage only
   logic sck_prev_q;
   logic cs_prev_q;
   logic sck_rise;
   logic sck_fall;
   logic cs_low;
   logic cs_rise;
   assign cs_low   = ~s2_q[PIN_CS];
   assign sck_rise = cs_low & s2_q[PIN_SCK] & ~sck_prev_q;
   assign sck_fall = cs_low & ~s2_q[PIN_SCK] & sck_prev_q;
   assign cs_rise  = s2_q[PIN_CS] & ~cs_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         sck_prev_q <= s2_q[PIN_SCK];
         cs_prev_q  <= s2_q[PIN_CS];
      end
   end

   // State, control and timer registers
   sfe_state_t  state_q;
   sfe_state_t  state_d;
   logic [31:0] tmr_q;
   logic [31:0] tmr_d;
   logic        wel_q;
   logic        wel_d;
   logic [3:0]  ctrl_q;
   logic [6:0]  edge_q;
   logic [31:0] in_sr_q;
   logic [7:0]  op_q;
   logic        tb;
   logic [2:0]  plevel;
   assign tb     = ctrl_q[CTRL_TB];
   assign plevel = ctrl_q[CTRL_PL_HI:CTRL_PL_LO];

   // Which opcodes the current state will recognise at all
   logic op_ok;
   assign op_ok = (state_q == ST_IDLE) ? 1'b1 :
                  (state_q == ST_ERASE) ? (op_q == OP_STATUS) :
                  (state_q == ST_PD) ? (op_q == OP_RELEASE) :
                  1'b0;

   // Dual input phase of 92h: address and mode bits arrive on io1:io0
   logic dual_in;
   logic dual_out;
   assign dual_in  = (op_q == OP_MFR_DUAL) && (edge_q >= EDGE_OP) && (edge_q < EDGE_DUAL);
   assign dual_out = (op_q == OP_MFR_DUAL);

   // Shift in on rising edges, MSB first; frame counters restart on deselect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_q  <= 7'h00;
         in_sr_q <= 32'h00000000;
         op_q    <= 8'h00;
      end else if (s2_q[PIN_CS]) begin
         edge_q <= 7'h00;
      end else if (sck_rise) begin
         edge_q <= (edge_q == EDGE_MAX) ? edge_q : edge_q + 7'h01;
         if (dual_in) begin
            in_sr_q <= {in_sr_q[29:0], s2_q[PIN_IO1], s2_q[PIN_IO0]};
         end else begin
            in_sr_q <= {in_sr_q[30:0], s2_q[PIN_IO0]};
         end
         if (edge_q == EDGE_OP - 7'h01) begin
            op_q <= {in_sr_q[6:0], s2_q[PIN_IO0]};
         end
      end
   end

   // Protection window: 2^(level-1) blocks from top or bottom, level 4 and up covers all
   logic [3:0] prot_n;
   logic [3:0] blk_idx;
   logic       blk_prot;
   assign blk_idx  = {1'b0, in_sr_q[18:16]};
   assign prot_n   = (plevel >= PL_ALL) ? BLK_COUNT : 4'(4'h1 << (plevel - 3'h1));
   assign blk_prot = (plevel == PL_NONE) ? 1'b0 :
                     tb ? (blk_idx < prot_n) : (blk_idx >= BLK_COUNT - prot_n);

   // Frame-end decode; exact length checks discard badly terminated frames, except that any release frame longer than the opcode is accepted
   logic end_ok;
   logic len_op;
   logic len_addr;
   logic do_wren;
   logic do_wrdi;
   logic do_blk;
   logic do_chip;
   logic do_pd;
   logic do_rel1;
   logic do_rel2;
   assign end_ok   = cs_rise & op_ok & (state_q != ST_ERASE);
   assign len_op   = (edge_q == EDGE_OP);
   assign len_addr = (edge_q == EDGE_ADDR);
   assign do_wren  = end_ok & (state_q == ST_IDLE) & (op_q == OP_WREN) & len_op;
   assign do_wrdi  = end_ok & (state_q == ST_IDLE) & (op_q == OP_WRDI) & len_op;
   assign do_blk   = end_ok & (state_q == ST_IDLE) & (op_q == OP_BLK_ERA) & len_addr
                     & wel_q & ~blk_prot;
   assign do_chip  = end_ok & (state_q == ST_IDLE) & len_op & wel_q
                     & ((op_q == OP_CHIP_A) | (op_q == OP_CHIP_B))
                     & (plevel == PL_NONE);
   assign do_pd    = end_ok & (state_q == ST_IDLE) & (op_q == OP_PDOWN) & len_op;
   assign do_rel1  = end_ok & (state_q == ST_PD) & len_op;
   assign do_rel2  = end_ok & (state_q == ST_PD) & (edge_q > EDGE_OP);

   // Sequencer for the self-timed cycles
   always_comb begin
      state_d = state_q;
      tmr_d   = (tmr_q > TMR_ONE) ? tmr_q - TMR_ONE : tmr_q;
      wel_d   = wel_q;
      case (state_q)
         ST_IDLE: begin
            if (do_wren) begin
               wel_d = 1'b1;
            end else if (do_wrdi) begin
               wel_d = 1'b0;
            end else if (do_blk) begin
               state_d = ST_ERASE;
               tmr_d   = BLOCK_ERASE_CYC;
            end else if (do_chip) begin
               state_d = ST_ERASE;
               tmr_d   = CHIP_ERASE_CYC;
            end else if (do_pd) begin
               state_d = ST_PD_ENTRY;
               tmr_d   = PD_ENTRY_CYC;
            end
         end
         ST_ERASE: begin
            if (tmr_q <= TMR_ONE) begin
               state_d = ST_IDLE;
               wel_d   = 1'b0;
            end
         end
         ST_PD_ENTRY: begin
            if (tmr_q <= TMR_ONE) begin
               state_d = ST_PD;
            end
         end
         ST_PD: begin
            if (do_rel2) begin
               state_d = ST_RELEASE;
               tmr_d   = REL2_CYC;
            end else if (do_rel1) begin
               state_d = ST_RELEASE;
               tmr_d   = REL1_CYC;
            end
         end
         ST_RELEASE: begin
            if (tmr_q <= TMR_ONE) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Reset lands in normal operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         tmr_q   <= 32'h00000000;
         wel_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
         wel_q   <= wel_d;
      end
   end

   // Erase request toward the array, address captured at the accepting deselect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_start <= 1'b0;
         erase_chip  <= 1'b0;
         erase_addr  <= 24'h000000;
      end else begin
         erase_start <= do_blk | do_chip;
         if (do_blk | do_chip) begin
            erase_chip <= do_chip;
            erase_addr <= do_chip ? 24'h000000 : {in_sr_q[23:16], 16'h0000};
         end
      end
   end

   assign busy       = (state_q == ST_ERASE);
   assign power_down = (state_q == ST_PD);

   // Readout word selection; status stays live so repeated reads track busy
   logic [7:0]  status_byte;
   logic [6:0]  out_len;
   logic [6:0]  out_start;
   logic [63:0] out_word;
   logic        swap_q;
   logic        swap_now;
   logic        swap_sel;
   logic        out_act_q;
   assign status_byte = {2'b00, tb, plevel, wel_q, busy};
   assign swap_now    = dual_out ? in_sr_q[8] : in_sr_q[0];
   assign swap_sel    = out_act_q ? swap_q : swap_now;
   assign out_len     = (op_q == OP_STATUS) ? LEN_BYTE :
                        (op_q == OP_RELEASE) ? LEN_BYTE :
                        (op_q == OP_MFR_DEV) ? LEN_PAIR :
                        (op_q == OP_MFR_DUAL) ? LEN_PAIR :
                        (op_q == OP_UNIQUE) ? LEN_UNIQ :
                        (op_q == OP_JEDEC) ? LEN_JED : LEN_NONE;
   assign out_start   = (op_q == OP_RELEASE) ? EDGE_ADDR :
                        (op_q == OP_MFR_DEV) ? EDGE_ADDR :
                        (op_q == OP_MFR_DUAL) ? EDGE_DUAL :
                        (op_q == OP_UNIQUE) ? EDGE_UNIQ : EDGE_OP;
   assign out_word    = (op_q == OP_STATUS) ? {56'h0, status_byte} :
                        (op_q == OP_RELEASE) ? {56'h0, DEV_ID} :
                        (op_q == OP_UNIQUE) ? UNIQUE_ID :
                        (op_q == OP_JEDEC) ? {40'h0, MFR_ID, MEM_TYPE, CAPACITY} :
                        swap_sel ? {48'h0, DEV_ID, MFR_ID} : {48'h0, MFR_ID, DEV_ID};

   // Bit pointer walks down and wraps so the word repeats until deselect
   logic       out_go;
   logic [6:0] ptr_q;
   logic [6:0] p_cur;
   logic [6:0] step;
   logic [6:0] ptr_nx;
   assign out_go = op_ok & (out_len != LEN_NONE) & (edge_q >= out_start);
   assign step   = dual_out ? 7'h02 : 7'h01;
   assign p_cur  = out_act_q ? ptr_q : out_len - 7'h01;
   assign ptr_nx = (p_cur < step) ? p_cur + out_len - step : p_cur - step;

   // Drive on falling edges; dual mode puts the higher bit on io1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_act_q <= 1'b0;
         swap_q    <= 1'b0;
         ptr_q     <= 7'h00;
         io0_out   <= 1'b0;
         io1_out   <= 1'b0;
      end else if (s2_q[PIN_CS]) begin
         out_act_q <= 1'b0;
      end else if (sck_fall && out_go) begin
         out_act_q <= 1'b1;
         swap_q    <= swap_sel;
         ptr_q     <= ptr_nx;
         io1_out   <= out_word[p_cur[5:0]];
         io0_out   <= out_word[p_cur[5:0] - 6'h01];
      end
   end

   assign io1_oe = out_act_q & cs_low;
   assign io0_oe = out_act_q & cs_low & dual_out;

   // APB slave: zero wait states, read data captured in the setup cycle
   logic apb_hit;
   logic ctrl_wr;
   assign apb_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
   assign ctrl_wr = psel & penable & pwrite & (paddr == ADDR_CTRL);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~apb_hit;

   // Protection changes take effect for the next erase decision only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         prdata <= 32'h00000000;
      end else begin
         if (ctrl_wr) begin
            ctrl_q <= pwdata[CTRL_PL_HI:0];
         end
         if (psel && !penable) begin
            if (paddr == ADDR_CTRL) begin
               prdata <= {28'h0, ctrl_q};
            end else if (paddr == ADDR_STATUS) begin
               prdata <= {29'h0, power_down, wel_q, busy};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

   // Assertions
   localparam int PD_LIM = int'(PD_ENTRY_CYC) + 2;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pd_cmd;
      cs_rise && (state_q == ST_IDLE) && (op_q == OP_PDOWN) && (edge_q == EDGE_OP);
   endsequence
   sequence s_rel_cmd;
      cs_rise && (state_q == ST_PD) && (op_q == OP_RELEASE) && (edge_q == EDGE_OP);
   endsequence

   a_wel_cleared:  assert property ($fell(busy) |-> !wel_q)
      else $error("erase finished with latch still set");
   a_erase_wel:    assert property (erase_start |-> $past(wel_q))
      else $error("erase started without write enable");
   a_blk_len:      assert property (erase_start && !erase_chip |->
                                    $past(edge_q) == EDGE_ADDR)
      else $error("block erase from wrong frame length");
   a_blk_prot:     assert property (erase_start && !erase_chip |-> !$past(blk_prot))
      else $error("protected block erased");
   a_chip_prot:    assert property (erase_start && erase_chip |->
                                    $past(plevel) == PL_NONE)
      else $error("chip erase with protection set");
   a_busy_hold:    assert property (erase_start |-> busy [*8])
      else $error("busy dropped early");
   a_pd_quiet:     assert property (power_down |->
                                    !io0_oe && !(io1_oe && op_q != OP_RELEASE))
      else $error("output driven in power-down");
   a_pd_entry:     assert property (s_pd_cmd |-> ##[1:PD_LIM] power_down)
      else $error("power-down not entered in time");
   a_rel_leave:    assert property (s_rel_cmd |=> !power_down && !busy)
      else $error("release not started");
   a_abh_busy:     assert property (busy && cs_rise && op_q == OP_RELEASE
                                    && tmr_q > TMR_ONE |=> busy)
      else $error("release disturbed erase");

endmodule

// File: verif/sfe_spi_host.sv
// Purpose: SPI host model that frames instructions for the command block
// Assumes: Mode 0, sck idles low, half period of 5 pclk
// Notes:   Data line toggles while the device talks, so no stale bit looks valid
`timescale 1ns/100ps
module sfe_spi_host (
   input  wire logic pclk, // System clock
   input  wire logic so,   // Data from device
   input  wire logic so0,  // Lower data line from device, dual read
   output logic      sck,  // Serial clock
   output logic      cs_n, // Chip select, low
   output logic      si,   // Data to device
   output logic      si1   // Upper line to device; idles at the pull-up level
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      si1 = 1'b1;
   end
   // 92h frame: opcode on si, then address and mode bits two per clock, io1 high bit
   task automatic dual_id(input logic [39:0] tx, input int npair, output logic [63:0] rx);
      rx = '0;
      cs_n <= 1'b0;
      for (int i = 0; i < 24 + npair; i++) begin
         if (i < 8) begin
            si <= tx[39-i];
         end else if (i < 24) begin
            si1 <= tx[47-2*i];
            si  <= tx[46-2*i];
         end else begin
            si1 <= 1'b1;
            si  <= ~si;
         end
         repeat (5) @(posedge pclk);
         sck <= 1'b1;
         if (i >= 24) rx = {rx[61:0], so, so0};
         repeat (5) @(posedge pclk);
         sck <= 1'b0;
      end
      repeat (2) @(posedge pclk);
      cs_n <= 1'b1;
      repeat (20) @(posedge pclk);
   endtask
   // One frame: ntx bits sent MSB first, then nrx bits taken on rising edges
   task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [63:0] rx);
      rx = '0;
      cs_n <= 1'b0;
      for (int i = 0; i < ntx + nrx; i++) begin
         si <= (i < ntx) ? tx[ntx-1-i] : ~si;
         repeat (5) @(posedge pclk);
         sck <= 1'b1;
         if (i >= ntx) rx = {rx[62:0], so};
         repeat (5) @(posedge pclk);
         sck <= 1'b0;
      end
      // Deselect right after the last bit, then stay idle long enough
      repeat (2) @(posedge pclk);
      cs_n <= 1'b1;
      repeat (20) @(posedge pclk);
   endtask
endmodule

// File: verif/sfe_flash_cmd_tb_top.sv
// Purpose: Self-checking bench for the flash command block
// Assumes: Short erase counts so runs stay brief
// Notes:   io1 has a pull-up when nobody drives it
`timescale 1ns/100ps
module sfe_flash_cmd_tb_top;
   import sfe_pkg::*;
   localparam logic [7:0]  MFR = 8'hA5;                  // Arbitrary value
   localparam logic [7:0]  DEV = 8'h3C;                  // Arbitrary value
   localparam logic [63:0] UID = 64'hFEDCBA9876543210;   // Arbitrary value
   localparam int          BEC = 400;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        sck, cs_n, si, si1, io0_out, io0_oe, io1_out, io1_oe;
   logic        erase_start, erase_chip, busy, power_down;
   logic [23:0] erase_addr;
   logic [63:0] rx;
   int          failures, checks, n_er, n_busy;
   wire         io0 = io0_oe ? io0_out : si;
   wire         io1 = io1_oe ? io1_out : si1;   // Host holds pull-up level when idle
   sfe_flash_cmd #(.BLOCK_ERASE_CYC(BEC), .CHIP_ERASE_CYC(64), .MFR_ID(MFR), .DEV_ID(DEV),
      .MEM_TYPE(8'h44), .CAPACITY(8'h17), .UNIQUE_ID(UID)) dut_u (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .spi_sck(sck),
      .spi_cs_n(cs_n), .io0_in(io0), .io0_out(io0_out), .io0_oe(io0_oe), .io1_in(io1),
      .io1_out(io1_out), .io1_oe(io1_oe), .erase_start(erase_start),
      .erase_chip(erase_chip), .erase_addr(erase_addr), .busy(busy), .power_down(power_down));
   sfe_spi_host host_u (.pclk(pclk), .so(io1), .so0(io0), .sck(sck), .cs_n(cs_n), .si(si),
      .si1(si1));
   always #5 pclk = ~pclk;
   // Count accepted erases and busy cycles
   always @(posedge pclk) begin
      n_er <= n_er + (erase_start === 1'b1);
      n_busy <= n_busy + (busy === 1'b1);
   end
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // APB transfer; waits for pready, releases only after it is seen
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {failures, checks, n_er, n_busy} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("pdown", power_down, 0);
      apb(ADDR_CTRL, 0, 0);
      chk("ctrl", r, 0);
      apb(12'h008, 0, 0);
      chk("slverr", err, 1);
      host_u.xfer(OP_JEDEC, 8, 24, rx);
      chk("jedec", rx, {MFR, 16'h4417});
      host_u.xfer({OP_MFR_DEV, 24'h0}, 32, 32, rx);
      chk("id90a", rx, {MFR, DEV, MFR, DEV});
      host_u.xfer({OP_MFR_DEV, 24'h1}, 32, 16, rx);
      chk("id90b", rx, {DEV, MFR});
      host_u.dual_id({OP_MFR_DUAL, 24'h000001, 8'hF0}, 16, rx);
      chk("id92", rx, {DEV, MFR, DEV, MFR});
      host_u.xfer({OP_UNIQUE, 32'h0}, 40, 64, rx);
      chk("uid", rx, UID);
      host_u.xfer({OP_RELEASE, 24'h0}, 32, 16, rx);
      chk("devid", rx, {DEV, DEV});
      repeat (200) @(posedge pclk);
      host_u.xfer({OP_BLK_ERA, 24'h010000}, 32, 0, rx);
      chk("nowel", n_er, 0);
      host_u.xfer(OP_WREN, 8, 0, rx);
      host_u.xfer({OP_BLK_ERA, 24'h010000, 1'b0}, 33, 0, rx);
      chk("badcs", n_er, 0);
      host_u.xfer({OP_BLK_ERA, 24'h01ABCD}, 32, 0, rx);
      chk("blk", {n_er[7:0], erase_chip, erase_addr}, {8'h1, 1'b0, 24'h010000});
      host_u.xfer(OP_STATUS, 8, 8, rx);
      chk("spistat", rx, 8'h03);
      host_u.xfer(OP_RELEASE, 8, 0, rx);
      chk("abbusy", busy, 1);
      repeat (BEC) @(posedge pclk);
      apb(ADDR_STATUS, 0, 0);
      chk("done", {n_busy, r}, {BEC, 32'h0});
      apb(ADDR_CTRL, 1, 32'h8);
      host_u.xfer(OP_WREN, 8, 0, rx);
      host_u.xfer(OP_CHIP_A, 8, 0, rx);
      apb(ADDR_CTRL, 1, 32'h2);
      host_u.xfer({OP_BLK_ERA, 24'h070000}, 32, 0, rx);
      chk("prot", n_er, 1);
      apb(ADDR_CTRL, 1, 32'h3);
      host_u.xfer({OP_BLK_ERA, 24'h000000}, 32, 0, rx);
      chk("protlo", n_er, 1);
      apb(ADDR_CTRL, 1, 32'h0);
      host_u.xfer(OP_WREN, 8, 0, rx);
      host_u.xfer(OP_CHIP_B, 8, 0, rx);
      chk("chip", {n_er[7:0], erase_chip, erase_addr}, {8'h2, 1'b1, 24'h0});
      repeat (100) @(posedge pclk);
      host_u.xfer(OP_PDOWN, 8, 0, rx);
      repeat (PD_ENTRY_CYC) @(posedge pclk);
      chk("pd", power_down, 1);
      host_u.xfer(OP_STATUS, 8, 8, rx);
      chk("pdspi", rx, 8'hFF);
      host_u.xfer(OP_WREN, 8, 0, rx);
      apb(ADDR_STATUS, 0, 0);
      chk("pdstat", r, 32'h4);
      host_u.xfer(OP_RELEASE, 8, 0, rx);
      chk("rel", power_down, 0);
      repeat (REL1_CYC) @(posedge pclk);
      host_u.xfer(OP_WREN, 8, 0, rx);
      apb(ADDR_STATUS, 0, 0);
      chk("relstat", r, 32'h2);
      host_u.xfer(OP_PDOWN, 8, 0, rx);
      repeat (PD_ENTRY_CYC) @(posedge pclk);
      host_u.xfer({OP_RELEASE, 24'h0}, 32, 8, rx);
      chk("pdid", rx, DEV);
      repeat (REL2_CYC) @(posedge pclk);
      host_u.xfer(OP_WRDI, 8, 0, rx);
      apb(ADDR_STATUS, 0, 0);
      chk("rel2", r, 32'h0);
      tally_and_finish();
   end
endmodule
